// [verilog/cor_regs.sv]
// option words of the converter command set and the logic they steer
// assumes a command decoder on clk delivering decoded reads and writes,
// and same-clock status strobes from the fault, strap and measurement logic
`timescale 1ns/1ps

// Notes on behaviour
// [RULE_01] averaging code selects 16, 8 or 32 samples
// [RULE_02] averaging defaults to 16, nonvolatile value may replace
// [RULE_03] code 01 passes every sample straight through
// [RULE_04] auto mask: mask set faults after alert response
// [RULE_05] without auto mask alert reasserts; host masks
// [RULE_06] divider field forces half, quarter or eighth
// [RULE_07] divider field zero follows loop scale factor
// [RULE_08] invalid strap keeps master off unless enabled
// [RULE_09] drive enable bit lets master run immediately
// [RULE_10] restore bit reloads output target on shutdowns
// [RULE_11] strap disable takes target default from nonvolatile
// [RULE_12] low margin restore value fff7h or fff1h
// [RULE_13] high margin restore value 0009h or 000fh
// [RULE_14] misc word read, write and storable
// [RULE_15] overvoltage fault latches low-side switch on
// [RULE_16] release zero: hold until startup or clear
// [RULE_17] release one: off once feedback below 0.2 V
// [RULE_18] readback disabled freezes all telemetry values
// [RULE_19] reserved bits read zero, ignore writes
// [RULE_20] margin steps reload whenever defaults are restored
module cor_regs (
  input  wire logic                clk,
  input  wire logic                rst,
  // decoded command transfers
  input  wire logic                cmd_valid,
  input  wire logic                cmd_write,
  input  wire logic [7:0]          cmd_code,
  input  wire logic [15:0]         cmd_wdata,
  output logic                     cmd_hit,
  output logic                     rd_valid,
  output logic [15:0]              rd_data,
  // nonvolatile image
  input  wire logic                store_all,
  input  wire logic                restore_defaults,
  input  wire logic [15:0]         nvm_user_word,
  input  wire logic [15:0]         nvm_misc_word,
  output logic                     nvm_write,
  output logic [15:0]              nvm_user_image,
  output logic [15:0]              nvm_misc_image,
  // telemetry
  input  wire logic                sample_valid,
  input  wire cor_pkg::cor_chan_t  sample_chan,
  input  wire logic [15:0]         sample_data,
  output logic [15:0]              vout_readback,
  output logic [15:0]              current_readback,
  output logic [15:0]              temp_readback,
  input  wire cor_pkg::cor_scale_t loop_scale_factor,
  output cor_pkg::cor_div_t        divider_sel,
  // alerts
  input  wire logic [7:0]          fault_active,
  input  wire logic                ara_done,
  input  wire logic                clear_faults,
  output logic [7:0]               auto_alert_mask,
  // strap and drive
  input  wire logic                strap_done,
  input  wire logic                strap_valid,
  input  wire logic                loop_master,
  input  wire logic                operation_on,
  output logic                     invalid_strap_status,
  output logic                     vout_default_from_nvm,
  output logic                     master_drive_enable,
  // shutdown restore
  input  wire logic                fault_shutdown,
  input  wire logic                fault_restart,
  input  wire logic                controlled_shutdown,
  input  wire logic                low_vin,
  output logic                     vout_restore,
  output logic [15:0]              margin_low_step,
  output logic [15:0]              margin_high_step,
  // overvoltage low-side control
  input  wire logic                ov_fault,
  input  wire logic                ov_response_ignore,
  input  wire logic                output_startup,
  input  wire logic                disabled_state,
  input  wire logic                fb_valid,
  input  wire logic [11:0]         fb_mv,
  output logic                     lowside_on
);
  import cor_pkg::*;

  // ==========================================================================
  // option words
  logic [15:0] user_option_word_reg;
  logic [15:0] misc_option_word_reg;
  logic        wr_user, wr_misc, rd_req;
  assign wr_user = cmd_valid && cmd_write && cmd_code == CMD_USER_OPTIONS;
  assign wr_misc = cmd_valid && cmd_write && cmd_code == CMD_MISC_OPTIONS;
  assign rd_req  = cmd_valid && !cmd_write;
  assign cmd_hit = cmd_code == CMD_USER_OPTIONS || cmd_code == CMD_MISC_OPTIONS;
  always_ff @(posedge clk) begin
    if (rst) begin
      user_option_word_reg <= USER_RESET;
      misc_option_word_reg <= MISC_RESET;
    end else if (restore_defaults) begin
      // nonvolatile image replaces the power-up defaults
      user_option_word_reg <= nvm_user_word & USER_WR_MASK;   // see [RULE_02]
      misc_option_word_reg <= nvm_misc_word & MISC_WR_MASK;   // see [RULE_19]
    end else begin
      if (wr_user) begin
        user_option_word_reg <= cmd_wdata & USER_WR_MASK;     // see [RULE_19]
      end
      if (wr_misc) begin
        misc_option_word_reg <= cmd_wdata & MISC_WR_MASK;     // see [RULE_14]
      end
    end
  end

  // ==========================================================================
  // read answer, one cycle after the request
  logic [15:0] rd_mux;
  assign rd_mux = (cmd_code == CMD_USER_OPTIONS) ? user_option_word_reg :
                  (cmd_code == CMD_MISC_OPTIONS) ? misc_option_word_reg : 16'h0000;
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        rd_data <= rd_mux;                                    // see [RULE_14]
      end
    end
  end

  // ==========================================================================
  // store to nonvolatile memory
  always_ff @(posedge clk) begin
    if (rst) begin
      nvm_write      <= 1'b0;
      nvm_user_image <= '0;
      nvm_misc_image <= '0;
    end else begin
      nvm_write <= store_all;
      if (store_all) begin
        nvm_user_image <= user_option_word_reg & USER_NVM_MASK;
        nvm_misc_image <= misc_option_word_reg;               // see [RULE_14]
      end
    end
  end

  // ==========================================================================
  // field views
  cor_avg_t avg_sel;
  cor_div_t range_sel;
  logic     readback_enable, vout_only, auto_alert_mask_enable, invalid_strap_drive_enable;
  logic     restore_target_on_shutdown, strap_select_disable, margin_low_restore_select;
  logic     margin_high_restore_select, ov_release_select;
  assign avg_sel    = cor_avg_t'(user_option_word_reg[U_AVG_LSB +: 2]);
  assign range_sel  = cor_div_t'(user_option_word_reg[U_RANGE_LSB +: 2]);
  assign readback_enable            = user_option_word_reg[U_READBACK_EN];
  assign vout_only                  = user_option_word_reg[U_VOUT_ONLY];
  assign auto_alert_mask_enable     = user_option_word_reg[U_AUTO_ALERT];
  assign invalid_strap_drive_enable = user_option_word_reg[U_DRIVE_INVALID];
  assign restore_target_on_shutdown = user_option_word_reg[U_RESTORE_VOUT];
  assign strap_select_disable       = user_option_word_reg[U_STRAP_DIS];
  assign margin_low_restore_select  = user_option_word_reg[U_MARGIN_LO_SEL];
  assign margin_high_restore_select = user_option_word_reg[U_MARGIN_HI_SEL];
  assign ov_release_select          = misc_option_word_reg[M_OV_RELEASE];

  // ==========================================================================
  // telemetry averaging, one averager per channel
  logic [15:0] ch_result [3];
  logic [2:0]  ch_valid;
  logic [2:0]  ch_take;
  generate
    for (genvar i = 0; i < 3; i++) begin : g_chan
      // vout-only mode starves the current and temperature channels
      assign ch_take[i] = sample_valid && readback_enable &&       // see [RULE_18]
                          sample_chan == cor_chan_t'(i) &&
                          (i == 0 || !vout_only);
      cor_avg u_avg (
        .clk          (clk),
        .rst          (rst),
        .sample_valid (ch_take[i]),
        .sample_data  (sample_data),
        .depth_sel    (avg_sel),                                   // see [RULE_01]
        .result       (ch_result[i]),
        .result_valid (ch_valid[i])
      );
    end
  endgenerate
  // held copies so disabled readback keeps the last values
  always_ff @(posedge clk) begin
    if (rst) begin
      vout_readback    <= '0;
      current_readback <= '0;
      temp_readback    <= '0;
    end else if (readback_enable) begin                            // see [RULE_18]
      if (ch_valid[CH_VOUT]) begin
        vout_readback <= ch_result[CH_VOUT];
      end
      if (ch_valid[CH_IOUT]) begin
        current_readback <= ch_result[CH_IOUT];
      end
      if (ch_valid[CH_TEMP]) begin
        temp_readback <= ch_result[CH_TEMP];
      end
    end
  end

  // ==========================================================================
  // readback divider
  cor_div_t auto_div;
  assign auto_div    = (loop_scale_factor == SCALE_ONE)  ? DIV_HALF :
                       (loop_scale_factor == SCALE_HALF) ? DIV_QUARTER : DIV_EIGHTH; // see [RULE_07]
  assign divider_sel = (range_sel == DIV_AUTO) ? auto_div : range_sel;              // see [RULE_06]

  // ==========================================================================
  // alert masking after an alert response
  always_ff @(posedge clk) begin
    if (rst) begin
      auto_alert_mask <= '0;
    end else if (ara_done && auto_alert_mask_enable) begin
      // new masks win over a clear in the same cycle
      auto_alert_mask <= auto_alert_mask | fault_active;           // see [RULE_04]
    end else if (clear_faults) begin
      auto_alert_mask <= '0;
    end
    // with auto masking off nothing is added here, so alerts reassert  see [RULE_05]
  end

  // ==========================================================================
  // strap detection and master drive
  logic strap_bad;
  assign strap_bad = strap_done && !strap_valid && !strap_select_disable; // see [RULE_11]
  always_ff @(posedge clk) begin
    if (rst) begin
      invalid_strap_status <= 1'b0;
    end else if (strap_bad) begin
      invalid_strap_status <= 1'b1;
    end else if (strap_done && strap_valid) begin
      // only a fresh valid detection clears it, never a command
      invalid_strap_status <= 1'b0;                                // see [RULE_08]
    end
  end
  assign vout_default_from_nvm = strap_select_disable;                     // see [RULE_11]
  assign master_drive_enable   = operation_on &&
                                 (!loop_master || !invalid_strap_status ||
                                  invalid_strap_drive_enable);              // see [RULE_09]

  // ==========================================================================
  // output target restore on shutdown
  logic shutdown_event;
  assign shutdown_event = fault_shutdown || fault_restart ||
                          controlled_shutdown || low_vin;
  always_ff @(posedge clk) begin
    if (rst) begin
      vout_restore <= 1'b0;
    end else begin
      vout_restore <= restore_target_on_shutdown && shutdown_event;  // see [RULE_10]
    end
  end

  // ==========================================================================
  // margin step restore values
  logic [15:0] margin_low_default;
  logic [15:0] margin_high_default;
  assign margin_low_default  = margin_low_restore_select  ? MARGIN_LO_B : MARGIN_LO_A; // see [RULE_12]
  assign margin_high_default = margin_high_restore_select ? MARGIN_HI_B : MARGIN_HI_A; // see [RULE_13]
  always_ff @(posedge clk) begin
    if (rst) begin
      margin_low_step  <= MARGIN_LO_A;
      margin_high_step <= MARGIN_HI_A;
    end else if (restore_defaults) begin                           // see [RULE_20]
      margin_low_step  <= margin_low_default;
      margin_high_step <= margin_high_default;
    end
  end

  // ==========================================================================
  // overvoltage low-side latch
  logic ov_set;
  logic ov_release;
  assign ov_set     = ov_fault && !ov_response_ignore;                       // see [RULE_15]
  assign ov_release = ov_release_select ?
                      (fb_valid && fb_mv < FB_RELEASE_MV) :                  // see [RULE_17]
                      (output_startup || (clear_faults && disabled_state));  // see [RULE_16]
  always_ff @(posedge clk) begin
    if (rst) begin
      lowside_on <= 1'b0;
    end else if (ov_set) begin
      lowside_on <= 1'b1;
    end else if (ov_release) begin
      lowside_on <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset_defaults;
    $fell(rst) |-> avg_sel == AVG_16 && misc_option_word_reg == MISC_RESET;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) // see [RULE_02]
    else $error("option words not at defaults after reset");
  property p_readback_hold;
    !readback_enable |=> $stable(vout_readback) && $stable(current_readback) &&
                         $stable(temp_readback);
  endproperty
  a_readback_hold: assert property (p_readback_hold) // see [RULE_18]
    else $error("readback changed while disabled");
  property p_auto_mask;
    ara_done && auto_alert_mask_enable
      |=> (auto_alert_mask & $past(fault_active)) == $past(fault_active);
  endproperty
  a_auto_mask: assert property (p_auto_mask) // see [RULE_04]
    else $error("active faults not masked after alert response");
  property p_no_auto_mask;
    !auto_alert_mask_enable && !clear_faults |=> $stable(auto_alert_mask);
  endproperty
  a_no_auto_mask: assert property (p_no_auto_mask) // see [RULE_05]
    else $error("mask grew with auto masking off");
  property p_divider_auto;
    range_sel == DIV_AUTO && loop_scale_factor == SCALE_HALF |-> divider_sel == DIV_QUARTER;
  endproperty
  a_divider_auto: assert property (p_divider_auto) // see [RULE_07]
    else $error("divider does not follow loop scale");
  property p_strap_block;
    strap_bad |=> invalid_strap_status &&
      (!loop_master || invalid_strap_drive_enable || !master_drive_enable);
  endproperty
  a_strap_block: assert property (p_strap_block) // see [RULE_08]
    else $error("master driven despite invalid strap");
  property p_restore_vout;
    restore_target_on_shutdown && low_vin |=> vout_restore;
  endproperty
  a_restore_vout: assert property (p_restore_vout) // see [RULE_10]
    else $error("target not restored on low input");
  property p_margin_restore;
    restore_defaults && margin_low_restore_select
      |=> margin_low_step == MARGIN_LO_B &&
          margin_high_step == ($past(margin_high_restore_select) ? MARGIN_HI_B : MARGIN_HI_A);
  endproperty
  a_margin_restore: assert property (p_margin_restore) // see [RULE_12]
    else $error("margin steps not restored to selected values");
  property p_ov_latch;
    ov_fault && !ov_response_ignore |=> lowside_on;
  endproperty
  a_ov_latch: assert property (p_ov_latch) // see [RULE_15]
    else $error("low-side switch not latched on overvoltage");
  property p_ov_hold;
    lowside_on && !ov_release_select && !output_startup && !clear_faults |=> lowside_on;
  endproperty
  a_ov_hold: assert property (p_ov_hold) // see [RULE_16]
    else $error("low-side switch released early");
  property p_ov_fb_release;
    lowside_on && ov_release_select && fb_valid && fb_mv < FB_RELEASE_MV && !ov_fault
      |=> !lowside_on;
  endproperty
  a_ov_fb_release: assert property (p_ov_fb_release) // see [RULE_17]
    else $error("low-side switch kept on below release level");
  property p_reserved_zero;
    (user_option_word_reg & ~USER_WR_MASK) == 16'h0000 &&
    (misc_option_word_reg & ~MISC_WR_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // see [RULE_19]
    else $error("reserved bit set in an option word");
  c_ara_mask:   cover property (ara_done && auto_alert_mask_enable && fault_active != 8'h00);
  c_ov_cycle:   cover property (lowside_on ##1 !lowside_on);
  c_bypass_rb:  cover property (avg_sel == AVG_BYPASS && ch_valid[CH_VOUT]);
  c_strap_over: cover property (invalid_strap_status && master_drive_enable && loop_master);

endmodule // cor_regs

// [verilog/cor_pkg.sv]
// constants and types for the converter option word block
// assumes one 10 MHz clock and a command decoder that presents decoded transfers
package cor_pkg;

  // ==========================================================================
  // command codes and word images
  localparam logic [7:0]  CMD_USER_OPTIONS = 8'hE5;
  localparam logic [7:0]  CMD_MISC_OPTIONS = 8'hF0;
  localparam logic [15:0] USER_RESET       = 16'h0084;
  localparam logic [15:0] MISC_RESET       = 16'h0013;
  localparam logic [15:0] USER_WR_MASK     = 16'h7FFF;
  localparam logic [15:0] MISC_WR_MASK     = 16'h01D7;
  // mode and override bits have no nonvolatile backup
  localparam logic [15:0] USER_NVM_MASK    = 16'h7FE7;

  // ==========================================================================
  // user option word fields
  localparam int U_MARGIN_HI_SEL = 14;
  localparam int U_MARGIN_LO_SEL = 13;
  localparam int U_STRAP_DIS     = 12;
  localparam int U_RESTORE_VOUT  = 11;
  localparam int U_DRIVE_INVALID = 10;
  localparam int U_RANGE_LSB     = 8;
  localparam int U_AUTO_ALERT    = 7;
  localparam int U_AVG_LSB       = 5;
  localparam int U_OVERRIDE      = 4;
  localparam int U_VOUT_ONLY     = 3;
  localparam int U_READBACK_EN   = 2;
  localparam int U_RESET_PIN     = 1;
  localparam int U_NEG_LIMIT_DIS = 0;

  // misc option word fields
  localparam int M_OV_RELEASE    = 0;

  // ==========================================================================
  // encodings
  typedef enum logic [1:0] {
    AVG_16     = 2'h0,
    AVG_BYPASS = 2'h1,
    AVG_8      = 2'h2,
    AVG_32     = 2'h3
  } cor_avg_t;

  typedef enum logic [1:0] {
    DIV_AUTO    = 2'h0,
    DIV_EIGHTH  = 2'h1,
    DIV_QUARTER = 2'h2,
    DIV_HALF    = 2'h3
  } cor_div_t;

  typedef enum logic [1:0] {
    SCALE_ONE     = 2'h0,
    SCALE_HALF    = 2'h1,
    SCALE_QUARTER = 2'h2
  } cor_scale_t;

  typedef enum logic [1:0] {
    CH_VOUT = 2'h0,
    CH_IOUT = 2'h1,
    CH_TEMP = 2'h2
  } cor_chan_t;

  localparam logic [5:0] DEPTH_8     = 6'h08;
  localparam logic [5:0] DEPTH_16    = 6'h10;
  localparam logic [5:0] DEPTH_32    = 6'h20;
  localparam logic [2:0] SHIFT_8     = 3'h3;
  localparam logic [2:0] SHIFT_16    = 3'h4;
  localparam logic [2:0] SHIFT_32    = 3'h5;

  localparam logic [15:0] MARGIN_LO_A = 16'hFFF7;
  localparam logic [15:0] MARGIN_LO_B = 16'hFFF1;
  localparam logic [15:0] MARGIN_HI_A = 16'h0009;
  localparam logic [15:0] MARGIN_HI_B = 16'h000F;

  // feedback release threshold in millivolts
  localparam logic [11:0] FB_RELEASE_MV = 12'h0C8;

endpackage

// [verilog/cor_avg.sv]
// accumulating averager for one telemetry channel
// assumes samples arrive as one-cycle strobes on the same clock
`timescale 1ns/1ps

module cor_avg (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             sample_valid,
  input  wire logic [15:0]      sample_data,
  input  wire cor_pkg::cor_avg_t depth_sel,
  output logic [15:0]           result,
  output logic                  result_valid
);
  import cor_pkg::*;

  // ==========================================================================
  // depth decode
  logic [20:0] acc_reg;
  logic [5:0]  cnt_reg;
  cor_avg_t    depth_reg;
  logic [5:0]  depth_n;
  logic [2:0]  shift_n;
  logic [20:0] sum_next;
  logic        restart;
  logic        last;

  assign depth_n  = (depth_sel == AVG_8)  ? DEPTH_8 :
                    (depth_sel == AVG_32) ? DEPTH_32 : DEPTH_16;
  assign shift_n  = (depth_sel == AVG_8)  ? SHIFT_8 :
                    (depth_sel == AVG_32) ? SHIFT_32 : SHIFT_16;
  assign sum_next = acc_reg + {5'h00, sample_data};
  assign restart  = depth_sel != depth_reg;
  assign last     = cnt_reg == 6'(depth_n - 6'h01);

  // ==========================================================================
  // accumulate, then divide by a power of two
  always_ff @(posedge clk) begin
    result_valid <= 1'b0;
    depth_reg    <= depth_sel;
    if (rst) begin
      acc_reg   <= '0;
      cnt_reg   <= '0;
      result    <= '0;
      depth_reg <= AVG_16;
    end else if (restart) begin
      // a depth change drops the partial sum rather than mixing depths
      acc_reg <= '0;
      cnt_reg <= '0;
    end else if (sample_valid) begin
      if (depth_sel == AVG_BYPASS) begin              // see [RULE_03]
        result       <= sample_data;
        result_valid <= 1'b1;
      end else if (last) begin                        // see [RULE_01]
        result       <= 16'(sum_next >> shift_n);
        result_valid <= 1'b1;
        acc_reg      <= '0;
        cnt_reg      <= '0;
      end else begin
        acc_reg <= sum_next;
        cnt_reg <= 6'(cnt_reg + 6'h01);
      end
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_avg_count_bound;
    cnt_reg < DEPTH_32;
  endproperty
  a_avg_count_bound: assert property (p_avg_count_bound) // see [RULE_01]
    else $error("averager count ran past deepest setting");

  property p_avg_bypass_pass;
    sample_valid && !restart && depth_sel == AVG_BYPASS
      |=> result_valid && result == $past(sample_data);
  endproperty
  a_avg_bypass_pass: assert property (p_avg_bypass_pass) // see [RULE_03]
    else $error("bypass sample not passed straight through");

endmodule // cor_avg

// [test/cor_host.sv]
// host model issuing decoded option word reads and writes
// assumes requests are taken on rising clk
`timescale 1ns/1ps
module cor_host (
  input  wire logic        clk,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  // ====================
  // transfers
  initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;
  // idle lines inverted so a stale code is never taken for a new one
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'h1, w, c, d};
    @(negedge clk);
    {cmd_valid, cmd_code, cmd_wdata} = {1'h0, ~c, ~d};
    ok = w;
    for (int i = 0; i < 4 && !ok; i++) begin
      ok = rd_valid === 1'h1;
      q = rd_data;
      @(negedge clk);
    end
    @(negedge clk);
  endtask
endmodule // cor_host

// [test/cor_regs_tb_top.sv]
// self-checking bench for the converter option words
// assumes cor_regs fed by the cor_host model on a 10 MHz clock
`timescale 1ns/1ps
module cor_regs_tb_top;
  import cor_pkg::*;
  // ====================
  // signals
  logic clk = '0, rst = '1, cmd_valid, cmd_write, cmd_hit, rd_valid, nvm_write, ok;
  logic store_all = '0, restore_defaults = '0, sample_valid = '0, ara_done = '0;
  logic clear_faults = '0, strap_done = '0, strap_valid = '0, loop_master = '0;
  logic operation_on = '0, ov_fault = '0, ov_response_ignore = '0, fb_valid = '0;
  logic output_startup = '0, disabled_state = '0, invalid_strap_status, lowside_on;
  logic vout_default_from_nvm, master_drive_enable, vout_restore;
  logic [3:0] sd = '0;
  logic [7:0] cmd_code, auto_alert_mask, fault_active = '0;
  logic [11:0] fb_mv = '0;
  logic [15:0] cmd_wdata, rd_data, nvm_user_image, nvm_misc_image, vout_readback, q;
  logic [15:0] current_readback, temp_readback, margin_low_step, margin_high_step;
  logic [15:0] nvm_user_word = '0, nvm_misc_word = 16'h0013, sample_data = '0;
  cor_chan_t sample_chan = CH_VOUT;
  cor_scale_t loop_scale_factor = SCALE_ONE;
  cor_div_t divider_sel;
  int miscompares = 0, checks_done = 0;
  cor_regs uut (.*, .fault_shutdown(sd[0]), .fault_restart(sd[1]),
    .controlled_shutdown(sd[2]), .low_vin(sd[3]));
  cor_host h (.*);
  initial forever #50 clk = ~clk;
  // ====================
  // tasks
  task automatic ck(input logic [15:0] e, input logic [15:0] a);
    checks_done++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    h.xfer(1'h1, c, d, q, ok);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    h.xfer(1'h0, c, 16'h0000, q, ok);
    if (!ok) begin
      miscompares++;
      final_report();
    end
    ck(e, q);
  endtask
  task automatic pl(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = '0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ====================
  // sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = '0;
    rd(CMD_MISC_OPTIONS, 16'h0013);
    rd(CMD_USER_OPTIONS, 16'h0084);
    // the host leaves the inverse code standing, here the misc word's
    rd(8'h0F, 16'h0000);
    ck(16'h0001, 16'(cmd_hit));
    wr(CMD_MISC_OPTIONS, 16'hFFFF);
    rd(CMD_MISC_OPTIONS, 16'h01D7);
    pl(store_all);
    ck(16'h0001, 16'(nvm_write));
    ck(16'h01D7, nvm_misc_image);
    ck(16'h0084, nvm_user_image);
    wr(CMD_USER_OPTIONS, 16'h0004);
    for (int i = 0; i < 3; i++) begin
      loop_scale_factor = cor_scale_t'(i);
      #1 ck(16'(3 - i), 16'(divider_sel));
    end
    for (int i = 1; i < 4; i++) begin
      wr(CMD_USER_OPTIONS, 16'(i << 8 | 4));
      ck(16'(i), 16'(divider_sel));
    end
    sample_data = 16'h1234;
    wr(CMD_USER_OPTIONS, 16'h0024);
    pl(sample_valid);
    @(negedge clk);
    ck(16'h1234, vout_readback);
    for (int i = 1; i < 3; i++) begin
      sample_chan = cor_chan_t'(i);
      pl(sample_valid);
      @(negedge clk);
      ck(16'h1234, i == 1 ? current_readback : temp_readback);
    end
    sample_chan = CH_VOUT;
    wr(CMD_USER_OPTIONS, 16'h0044);
    for (int i = 0; i < 8; i++) begin
      {sample_valid, sample_data} = {1'h1, 16'(i * 2)};
      @(negedge clk);
    end
    sample_valid = '0;
    @(negedge clk);
    ck(16'h0007, vout_readback);
    wr(CMD_USER_OPTIONS, 16'h0020);
    pl(sample_valid);
    @(negedge clk);
    ck(16'h0007, vout_readback);
    nvm_user_word = 16'h00C4;
    wr(CMD_USER_OPTIONS, 16'h6000);
    pl(restore_defaults);
    ck(16'hFFF1, margin_low_step);
    ck(16'h000F, margin_high_step);
    rd(CMD_USER_OPTIONS, 16'h00C4);
    pl(restore_defaults);
    ck(16'hFFF7, margin_low_step);
    fault_active = 8'h5A;
    pl(ara_done);
    ck(16'h005A, 16'(auto_alert_mask));
    pl(clear_faults);
    wr(CMD_USER_OPTIONS, 16'h0044);
    pl(ara_done);
    ck(16'h0000, 16'(auto_alert_mask));
    {loop_master, operation_on} = 2'h3;
    pl(strap_done);
    ck(16'h0001, 16'(invalid_strap_status));
    ck(16'h0000, 16'(master_drive_enable));
    wr(CMD_USER_OPTIONS, 16'h0C00);
    ck(16'h0001, 16'(master_drive_enable));
    for (int i = 0; i < 4; i++) begin
      sd = 4'h1 << i;
      @(negedge clk);
      ck(16'h0001, 16'(vout_restore));
    end
    {sd, fb_mv} = {4'h0, 12'h0C7};
    pl(ov_fault);
    ck(16'h0001, 16'(lowside_on));
    pl(fb_valid);
    ck(16'h0000, 16'(lowside_on));
    wr(CMD_MISC_OPTIONS, 16'h0012);
    pl(ov_fault);
    pl(fb_valid);
    ck(16'h0001, 16'(lowside_on));
    pl(output_startup);
    ck(16'h0000, 16'(lowside_on));
    pl(ov_fault);
    disabled_state = 1'h1;
    pl(clear_faults);
    ck(16'h0000, 16'(lowside_on));
    wr(CMD_USER_OPTIONS, 16'h1000);
    ck(16'h0001, 16'(vout_default_from_nvm));
    final_report();
  end
endmodule // cor_regs_tb_top
